// ---- inc/lmm_pkg.sv ----
`default_nettype none
package lmm_pkg;
  // Clock and the slow time bases built from it
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_S       = 1;
  localparam int unsigned TICK_CYC     = TICK_S * CLK_HZ;
  localparam int unsigned HOUR_S       = 3600;
  // Data and address widths
  localparam int unsigned DW           = 16;
  localparam int unsigned AW           = 12;
  localparam logic [DW-1:0] RST_VAL    = 16'h0000;
  // Counter limits and thresholds, in register units
  localparam logic [DW-1:0] OPS_UNITS_MAX = 16'h0063;
  localparam logic [DW-1:0] OVL_THRESH    = 16'h044C;
  localparam logic [DW-1:0] OVL_TRIP      = 16'h4650;
  localparam logic [DW-1:0] AMB_SET       = 16'h02EE;
  localparam logic [DW-1:0] AMB_CLR       = 16'h028A;
  localparam logic [DW-1:0] SCALE_MILLI   = 16'h03E8;
  localparam logic [DW-1:0] TEMPCO_INV    = 16'h00FE;
  localparam logic [31:0]   WS_PER_UNIT   = 32'h00057E40;
  localparam logic [31:0]   PWR_DIV       = 32'h000186A0;
  localparam logic [31:0]   VA_DIV        = 32'h00000064;
  localparam logic [11:0]   ADC_FULL      = 12'hFFF;
  localparam logic [9:0]    DUTY_LAST     = 10'h3E7;
  // Control status word and logic input word bit positions
  localparam int unsigned CS_RUN    = 0;
  localparam int unsigned CS_DROP   = 1;
  localparam int unsigned CS_FAULT  = 6;
  localparam int unsigned CS_UV     = 7;
  localparam int unsigned CS_EXTMAJ = 11;
  localparam int unsigned CS_BATT   = 14;
  localparam int unsigned LI_UNUSED = 7;
  // Active fault codes that count as undervoltage
  localparam logic [4:0] FC_SUPPLY_UV = 5'h01;
  localparam logic [4:0] FC_BUS_UV    = 5'h02;
  // Register word indices; byte address is four times the index
  localparam logic [4:0] IDX_MAG_CUR  = 5'h00;
  localparam logic [4:0] IDX_MAG_VOLT = 5'h02;
  localparam logic [4:0] IDX_BUS_VOLT = 5'h03;
  localparam logic [4:0] IDX_COIL_RES = 5'h04;
  localparam logic [4:0] IDX_COIL_TMP = 5'h05;
  localparam logic [4:0] IDX_CMD_REF  = 5'h08;
  localparam logic [4:0] IDX_IN_PWR   = 5'h09;
  localparam logic [4:0] IDX_ENERGY   = 5'h0A;
  localparam logic [4:0] IDX_OPS_UNIT = 5'h0B;
  localparam logic [4:0] IDX_OPS_HUND = 5'h0C;
  localparam logic [4:0] IDX_HOURS    = 5'h0D;
  localparam logic [4:0] IDX_AN_ONE   = 5'h0E;
  localparam logic [4:0] IDX_AN_TWO   = 5'h0F;
  localparam logic [4:0] IDX_CUR_REF  = 5'h10;
  localparam logic [4:0] IDX_CUR_FB   = 5'h11;
  localparam logic [4:0] IDX_IN_PINS  = 5'h15;
  localparam logic [4:0] IDX_OUT_PINS = 5'h16;
  localparam logic [4:0] IDX_HS_TMP   = 5'h17;
  localparam logic [4:0] IDX_AMB_TMP  = 5'h18;
  localparam logic [4:0] IDX_OVL_ACC  = 5'h19;
  localparam logic [4:0] IDX_DUTY_ONE = 5'h1A;
  localparam logic [4:0] IDX_DUTY_TWO = 5'h1B;
  localparam logic [4:0] IDX_CTL_FLAG = 5'h1D;
endpackage : lmm_pkg
`default_nettype wire

// ---- hw/lmm_monitor_bank.sv ----
// Function
// - Units counter steps once per operation, wraps to zero after 99.
// - Hundreds counter steps once per hundred operations, wraps at ceiling.
// - Overload accumulator rises above 110% rated current, falls below it.
// - Magnet overload fault raised once accumulator reaches 18000.
// - Ambient fault sets at 75 C, clears only at 65 C.
// - Bit zero of each status word is its least significant bit.
// - Logic input word carries enable, direction, speeds, and module inputs.
// - Logic output word carries contactor and four programmable outputs.
// - Control word: run, drop, fault, external major fault, battery.
// - Status bit 7 set when active fault is undervoltage.
// - Duty cycle per output terminal reported in tenths of a percent.
// - Elapsed hours accumulate only while enabled, in whole hours.
// - Energy used accumulated and reported in tenths of a kilowatt-hour.
// - Coil resistance updated only in steady current, in milliohms.
// - Coil temperature estimated from cold resistance and steady resistance.
// - Magnet current from first terminal measurement, in tenths of ampere.
// - Magnet voltage from both terminals; bus voltage also in tenth volts.
// - Current reference reported as tenths of percent of rated current.
// - Current feedback reported as tenths of percent of rated current.
// - Each analog input reported as tenths of percent of full scale.
// - Heatsink and ambient temperatures reported in tenths of a degree.
// - Instantaneous input power from the DC supply reported in kilowatts.
`timescale 1ns/1ps
`default_nettype none
module lmm_monitor_bank #(
  parameter int unsigned TICK_CYCLES = lmm_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RST_I,
  // APB slave
  input  wire logic [lmm_pkg::AW-1:0]  PADDR_I,
  input  wire logic                    PSEL_I,
  input  wire logic                    PENABLE_I,
  input  wire logic                    PWRITE_I,
  input  wire logic [31:0]             PWDATA_I,
  output var  logic [31:0]             PRDATA_O,
  output var  logic                    PREADY_O,
  output var  logic                    PSLVERR_O,
  // Measurements from converter logic, same clock
  input  wire logic [lmm_pkg::DW-1:0]  TERM_ONE_CURRENT_I,
  input  wire logic [lmm_pkg::DW-1:0]  TERM_ONE_VOLTAGE_I,
  input  wire logic [lmm_pkg::DW-1:0]  TERM_TWO_VOLTAGE_I,
  input  wire logic [lmm_pkg::DW-1:0]  BUS_VOLTAGE_I,
  input  wire logic [lmm_pkg::DW-1:0]  SUPPLY_CURRENT_I,
  input  wire logic                    STEADY_I,
  input  wire logic [11:0]             ANALOG_ONE_I,
  input  wire logic [11:0]             ANALOG_TWO_I,
  input  wire logic [lmm_pkg::DW-1:0]  HEATSINK_TEMP_I,
  input  wire logic [lmm_pkg::DW-1:0]  AMBIENT_TEMP_I,
  // Setup values and control state, same clock
  input  wire logic [lmm_pkg::DW-1:0]  RATED_CURRENT_I,
  input  wire logic [lmm_pkg::DW-1:0]  COLD_RES_I,
  input  wire logic [lmm_pkg::DW-1:0]  COLD_TEMP_I,
  input  wire logic [lmm_pkg::DW-1:0]  CMD_REF_I,
  input  wire logic [lmm_pkg::DW-1:0]  CUR_REF_I,
  input  wire logic                    OPERATION_I,
  input  wire logic                    RUN_I,
  input  wire logic                    DROP_I,
  input  wire logic                    FAULT_I,
  input  wire logic [4:0]              FAULT_CODE_I,
  input  wire logic [4:0]              OUT_DRIVE_I,
  input  wire logic                    GATE_FIRST_I,
  input  wire logic                    GATE_SECOND_I,
  // Logic input pins, asynchronous
  input  wire logic [12:0]             LOGIC_IN_I,
  input  wire logic                    EXT_MAJOR_I,
  input  wire logic                    BATTERY_I,
  // Fault outputs
  output var  logic                    OVERLOAD_FAULT_O,
  output var  logic                    AMBIENT_FAULT_O
);
  import lmm_pkg::*;

  // Value times 1000 over full scale, zero when full scale is zero
  function automatic logic [DW-1:0] lmm_pct(input logic [DW-1:0] num,
                                            input logic [DW-1:0] full);
    logic [31:0] prod;
    prod = 32'(num) * 32'(SCALE_MILLI);
    if (full == RST_VAL)
      return RST_VAL;
    return DW'(prod / 32'(full));
  endfunction : lmm_pct

  logic [DW-1:0] mag_cur_r, mag_volt_r, bus_volt_r, coil_res_r, coil_tmp_r;
  logic [DW-1:0] cmd_ref_r, in_pwr_r, energy_r, ops_unit_r, ops_hund_r;
  logic [DW-1:0] hours_r, an_one_r, an_two_r, cur_ref_r, cur_fb_r;
  logic [DW-1:0] hs_tmp_r, amb_tmp_r, ovl_acc_r, ctl_flag_r;
  logic [DW-1:0] in_pins_r, out_pins_r;
  logic [DW-1:0] duty_r [2];
  logic [9:0]    hi_cnt_r [2];
  logic [9:0]    win_cnt_r;
  logic [14:0]   pin_meta_r, pin_sync_r;
  logic [31:0]   tick_cnt_r, ws_acc_r;
  logic [DW-1:0] hr_sec_r;
  logic          tick;
  logic          ovl_fault_r, amb_fault_r;
  logic [DW-1:0] volt_diff, volt_mag;
  logic [31:0]   pwr_w;
  logic [1:0]    gate;
  logic          setup_ph, access_ph, hit;
  logic [DW-1:0] rd_mux;
  logic [31:0]   prdata_r;

  // Two flops on every asynchronous pin before anything looks at it
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      pin_meta_r <= 15'h0000;
      pin_sync_r <= 15'h0000;
    end
    else
    begin
      pin_meta_r <= {BATTERY_I, EXT_MAJOR_I, LOGIC_IN_I};
      pin_sync_r <= pin_meta_r;
    end
  end

  // One-second enable pulse for energy and hours
  assign tick = (tick_cnt_r == TICK_CYCLES - 1);
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      tick_cnt_r <= 32'h00000000;
    else if (tick)
      tick_cnt_r <= 32'h00000000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
  end

  // Voltage sign follows terminal one minus terminal two; the
  // magnitude feeds resistance
  assign volt_diff = TERM_ONE_VOLTAGE_I - TERM_TWO_VOLTAGE_I;
  assign volt_mag  = volt_diff[DW-1] ? DW'(-volt_diff) : volt_diff;
  // Watts from tenth-volt times tenth-amp
  assign pwr_w = (32'(BUS_VOLTAGE_I) * 32'(SUPPLY_CURRENT_I)) / VA_DIV;

  // Plain measurements and percentages, refreshed every cycle
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      mag_cur_r  <= RST_VAL;
      mag_volt_r <= RST_VAL;
      bus_volt_r <= RST_VAL;
      cmd_ref_r  <= RST_VAL;
      in_pwr_r   <= RST_VAL;
      an_one_r   <= RST_VAL;
      an_two_r   <= RST_VAL;
      cur_ref_r  <= RST_VAL;
      cur_fb_r   <= RST_VAL;
      hs_tmp_r   <= RST_VAL;
      amb_tmp_r  <= RST_VAL;
    end
    else
    begin
      mag_cur_r  <= TERM_ONE_CURRENT_I;
      mag_volt_r <= volt_diff;
      bus_volt_r <= BUS_VOLTAGE_I;
      cmd_ref_r  <= CMD_REF_I;
      in_pwr_r   <= DW'(pwr_w / 32'(SCALE_MILLI));
      an_one_r   <= lmm_pct(DW'(ANALOG_ONE_I), DW'(ADC_FULL));
      an_two_r   <= lmm_pct(DW'(ANALOG_TWO_I), DW'(ADC_FULL));
      cur_ref_r  <= lmm_pct(CUR_REF_I, RATED_CURRENT_I);
      cur_fb_r   <= lmm_pct(TERM_ONE_CURRENT_I, RATED_CURRENT_I);
      hs_tmp_r   <= HEATSINK_TEMP_I;
      amb_tmp_r  <= AMBIENT_TEMP_I;
    end
  end

  // Resistance and temperature only move in steady current, else a
  // ramping coil would show a meaningless inductive value
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      coil_res_r <= RST_VAL;
      coil_tmp_r <= RST_VAL;
    end
    else if (STEADY_I && TERM_ONE_CURRENT_I != RST_VAL)
    begin
      coil_res_r <= DW'((32'(volt_mag) * 32'(SCALE_MILLI))
                        / 32'(TERM_ONE_CURRENT_I));
      // Signed so a coil colder than its reference reads below it
      if (COLD_RES_I != RST_VAL)
        coil_tmp_r <= DW'($signed(32'(COLD_TEMP_I))
                      + ($signed(32'(coil_res_r)) - $signed(32'(COLD_RES_I)))
                      * $signed(32'(TEMPCO_INV))
                      / $signed(32'(COLD_RES_I)));
    end
  end

  // Operation counters
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ops_unit_r <= RST_VAL;
      ops_hund_r <= RST_VAL;
    end
    else if (OPERATION_I)
    begin
      if (ops_unit_r == OPS_UNITS_MAX)
      begin
        ops_unit_r <= RST_VAL;
        ops_hund_r <= ops_hund_r + 16'h0001;
      end
      else
        ops_unit_r <= ops_unit_r + 16'h0001;
    end
  end

  // Energy in watt-seconds, drained in tenth-kWh steps one per cycle
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ws_acc_r <= 32'h00000000;
      energy_r <= RST_VAL;
    end
    else if (tick)
      ws_acc_r <= ws_acc_r + pwr_w;
    else if (ws_acc_r >= WS_PER_UNIT)
    begin
      ws_acc_r <= ws_acc_r - WS_PER_UNIT;
      energy_r <= energy_r + 16'h0001;
    end
  end

  // Enabled seconds roll into whole hours
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      hr_sec_r <= RST_VAL;
      hours_r  <= RST_VAL;
    end
    else if (tick && pin_sync_r[0])
    begin
      if (hr_sec_r == DW'(HOUR_S - 1))
      begin
        hr_sec_r <= RST_VAL;
        hours_r  <= hours_r + 16'h0001;
      end
      else
        hr_sec_r <= hr_sec_r + 16'h0001;
    end
  end

  // Overload accumulator saturates at both ends; exactly 110% holds
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      ovl_acc_r <= RST_VAL;
    else if (cur_fb_r > OVL_THRESH && ovl_acc_r != 16'hFFFF)
      ovl_acc_r <= ovl_acc_r + 16'h0001;
    else if (cur_fb_r < OVL_THRESH && ovl_acc_r != RST_VAL)
      ovl_acc_r <= ovl_acc_r - 16'h0001;
  end

  // Fault flags with the ambient hysteresis band
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      ovl_fault_r <= 1'b0;
      amb_fault_r <= 1'b0;
    end
    else
    begin
      ovl_fault_r <= (ovl_acc_r >= OVL_TRIP);
      if (amb_tmp_r >= AMB_SET)
        amb_fault_r <= 1'b1;
      else if (amb_tmp_r <= AMB_CLR)
        amb_fault_r <= 1'b0;
    end
  end
  assign OVERLOAD_FAULT_O = ovl_fault_r;
  assign AMBIENT_FAULT_O  = amb_fault_r;

  // Bit-mapped words, bit zero in the rightmost place
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      in_pins_r  <= RST_VAL;
      out_pins_r <= RST_VAL;
      ctl_flag_r <= RST_VAL;
    end
    else
    begin
      in_pins_r               <= {3'h0, pin_sync_r[12:0]};
      in_pins_r[LI_UNUSED]    <= 1'b0;
      out_pins_r              <= {11'h000, OUT_DRIVE_I};
      ctl_flag_r              <= RST_VAL;
      ctl_flag_r[CS_RUN]      <= RUN_I;
      ctl_flag_r[CS_DROP]     <= DROP_I;
      ctl_flag_r[CS_FAULT]    <= FAULT_I;
      ctl_flag_r[CS_UV]       <= FAULT_I && (FAULT_CODE_I == FC_SUPPLY_UV
                                 || FAULT_CODE_I == FC_BUS_UV);
      ctl_flag_r[CS_EXTMAJ]   <= pin_sync_r[13];
      ctl_flag_r[CS_BATT]     <= pin_sync_r[14];
    end
  end

  // Duty over a 1000-cycle window: each high cycle is one tenth percent
  assign gate = {GATE_SECOND_I, GATE_FIRST_I};
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I || win_cnt_r == DUTY_LAST)
      win_cnt_r <= 10'h000;
    else
      win_cnt_r <= win_cnt_r + 10'h001;
  end
  for (genvar g = 0; g < 2; g++)
  begin : g_duty
    always_ff @(posedge CORE_CLK_I)
    begin
      if (RST_I)
      begin
        hi_cnt_r[g] <= 10'h000;
        duty_r[g]   <= RST_VAL;
      end
      else if (win_cnt_r == DUTY_LAST)
      begin
        hi_cnt_r[g] <= 10'h000;
        duty_r[g]   <= DW'(hi_cnt_r[g]) + DW'(gate[g]);
      end
      else
        hi_cnt_r[g] <= hi_cnt_r[g] + 10'(gate[g]);
    end
  end

  // Read decode; unmapped words read zero and flag an error
  always_comb
  begin
    hit    = 1'b1;
    rd_mux = RST_VAL;
    case (PADDR_I[6:2])
      IDX_MAG_CUR:  rd_mux = mag_cur_r;
      IDX_MAG_VOLT: rd_mux = mag_volt_r;
      IDX_BUS_VOLT: rd_mux = bus_volt_r;
      IDX_COIL_RES: rd_mux = coil_res_r;
      IDX_COIL_TMP: rd_mux = coil_tmp_r;
      IDX_CMD_REF:  rd_mux = cmd_ref_r;
      IDX_IN_PWR:   rd_mux = in_pwr_r;
      IDX_ENERGY:   rd_mux = energy_r;
      IDX_OPS_UNIT: rd_mux = ops_unit_r;
      IDX_OPS_HUND: rd_mux = ops_hund_r;
      IDX_HOURS:    rd_mux = hours_r;
      IDX_AN_ONE:   rd_mux = an_one_r;
      IDX_AN_TWO:   rd_mux = an_two_r;
      IDX_CUR_REF:  rd_mux = cur_ref_r;
      IDX_CUR_FB:   rd_mux = cur_fb_r;
      IDX_IN_PINS:  rd_mux = in_pins_r;
      IDX_OUT_PINS: rd_mux = out_pins_r;
      IDX_HS_TMP:   rd_mux = hs_tmp_r;
      IDX_AMB_TMP:  rd_mux = amb_tmp_r;
      IDX_OVL_ACC:  rd_mux = ovl_acc_r;
      IDX_DUTY_ONE: rd_mux = duty_r[0];
      IDX_DUTY_TWO: rd_mux = duty_r[1];
      IDX_CTL_FLAG: rd_mux = ctl_flag_r;
      default:      hit    = 1'b0;
    endcase
    if (PADDR_I[1:0] != 2'h0 || PADDR_I[AW-1:7] != 5'h00)
      hit = 1'b0;
  end

  // Read data captured in the setup cycle so it leaves a flop
  assign setup_ph  = PSEL_I && !PENABLE_I;
  assign access_ph = PSEL_I && PENABLE_I;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      prdata_r <= 32'h00000000;
    else if (setup_ph)
      prdata_r <= (hit && !PWRITE_I) ? 32'(rd_mux) : 32'h00000000;
  end
  assign PRDATA_O  = prdata_r;
  assign PREADY_O  = 1'b1;
  // Writes are refused: nothing above looks at PWDATA_I
  assign PSLVERR_O = access_ph && (PWRITE_I || !hit);

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  property p_units_wrap;
    OPERATION_I && ops_unit_r == OPS_UNITS_MAX |=> ops_unit_r == RST_VAL;
  endproperty
  a_units_wrap: assert property (p_units_wrap)
    else $error("units counter did not wrap after 99");

  property p_hund_step;
    OPERATION_I && ops_unit_r == OPS_UNITS_MAX
      |=> ops_hund_r == $past(ops_hund_r) + 16'h0001;
  endproperty
  a_hund_step: assert property (p_hund_step)
    else $error("hundreds counter missed a step");

  property p_ovl_up;
    cur_fb_r > OVL_THRESH && ovl_acc_r != 16'hFFFF
      |=> ovl_acc_r == $past(ovl_acc_r) + 16'h0001;
  endproperty
  a_ovl_up: assert property (p_ovl_up)
    else $error("overload accumulator did not rise");

  property p_ovl_trip;
    ovl_acc_r >= OVL_TRIP |=> OVERLOAD_FAULT_O;
  endproperty
  a_ovl_trip: assert property (p_ovl_trip)
    else $error("overload fault missing at trip count");

  property p_amb_hold;
    AMBIENT_FAULT_O && amb_tmp_r > AMB_CLR |=> AMBIENT_FAULT_O;
  endproperty
  a_amb_hold: assert property (p_amb_hold)
    else $error("ambient fault cleared above lower limit");

  property p_unused_bit;
    !in_pins_r[LI_UNUSED] && in_pins_r[15:13] == 3'h0;
  endproperty
  a_unused_bit: assert property (p_unused_bit)
    else $error("unused logic input bit set");

  property p_hours_idle;
    !pin_sync_r[0] |=> $stable(hours_r);
  endproperty
  a_hours_idle: assert property (p_hours_idle)
    else $error("hours moved while disabled");

  property p_res_hold;
    !STEADY_I |=> $stable(coil_res_r);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("resistance changed outside steady state");

  property p_write_err;
    access_ph && PWRITE_I && !OPERATION_I
      |-> PSLVERR_O ##1 $stable(ops_unit_r);
  endproperty
  a_write_err: assert property (p_write_err)
    else $error("write not refused");
endmodule : lmm_monitor_bank
`default_nettype wire

// ---- verif/lift_magnet_monitor_bank_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module lift_magnet_monitor_bank_test;
  import lmm_pkg::*;
  // Bench state and design stimulus
  logic        clk, rst, psel, pen, pwr, op, stdy, run, drop, flt, ext;
  logic        batt, g1, g2, pready, pslverr, ovl_f, amb_f, err;
  logic [11:0] paddr, an1, an2;
  logic [31:0] pwdata, prdata, rd, a0;
  logic [15:0] t1c, t1v, t2v, busv, supc, hst, ambt, rated, cres, ctmp;
  logic [15:0] cmdr, curr;
  logic [4:0]  fcode, drv;
  logic [12:0] lin;
  logic [15:0] amb_tab [5] = '{16'h02ED, 16'h02EE, 16'h02BC, 16'h028B,
                               16'h028A};
  logic        af_tab  [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  int          bad_count, checked, cyc;

  // Short tick so an hour of enabled time fits in the run
  lmm_monitor_bank #(.TICK_CYCLES(10)) i_lmm_monitor_bank (
    .CORE_CLK_I(clk), .RST_I(rst), .PADDR_I(paddr), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .TERM_ONE_CURRENT_I(t1c), .TERM_ONE_VOLTAGE_I(t1v),
    .TERM_TWO_VOLTAGE_I(t2v), .BUS_VOLTAGE_I(busv),
    .SUPPLY_CURRENT_I(supc), .STEADY_I(stdy),
    .ANALOG_ONE_I(an1), .ANALOG_TWO_I(an2), .HEATSINK_TEMP_I(hst),
    .AMBIENT_TEMP_I(ambt), .RATED_CURRENT_I(rated), .COLD_RES_I(cres),
    .COLD_TEMP_I(ctmp), .CMD_REF_I(cmdr), .CUR_REF_I(curr),
    .OPERATION_I(op), .RUN_I(run), .DROP_I(drop), .FAULT_I(flt),
    .FAULT_CODE_I(fcode), .OUT_DRIVE_I(drv), .GATE_FIRST_I(g1),
    .GATE_SECOND_I(g2), .LOGIC_IN_I(lin), .EXT_MAJOR_I(ext),
    .BATTERY_I(batt), .OVERLOAD_FAULT_O(ovl_f), .AMBIENT_FAULT_O(amb_f));

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycles since reset release, for tick and hour arithmetic
  always @(posedge clk)
    if (!rst)
      cyc <= cyc + 1;

  // One APB transfer; an edge passes first so psel is never set twice.
  // A slave that never answers is caught by the watchdog, not here.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : bus

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
    `CHK(nm, 1'b0, err)
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Fault pins are looked at mid-cycle, away from the updating edge
  task automatic fchk(input string nm, input logic e, input logic ovl);
    @(negedge clk);
    `CHK(nm, e, (ovl ? ovl_f : amb_f))
    @(posedge clk);
  endtask : fchk

  task automatic pulse();
    op <= 1'b1;
    @(posedge clk);
    op <= 1'b0;
    @(posedge clk);
  endtask : pulse

  task automatic summarize();
    $display("Counts: checked %0d, bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // Watchdog sized well past the hour wait
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("Watchdog expired");
    summarize();
  end

  initial
  begin
    {rst, stdy, g1, batt, ext, run, drop, flt} = 8'hE0;
    {psel, pen, pwr, op, g2} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {t1c, rated, t1v, t2v} = {16'h03E8, 16'h03E8, 16'h07D0, 16'h01F4};
    {busv, supc, hst, ambt} = {16'h1388, 16'h03E8, 16'h0123, 16'h00FA};
    {cres, ctmp, cmdr, curr} = {16'h03E8, 16'h0014, 16'h0155, 16'h00FA};
    {an1, an2} = {12'hFFF, 12'h800};
    {fcode, drv, lin} = {5'h00, 5'h15, 13'h1FFF};
    bad_count = 0;
    checked = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(2100);
    rchk("mag_cur", 12'h000, 32'h03E8);
    rchk("mag_volt", 12'h008, 32'h05DC);
    rchk("bus_volt", 12'h00C, 32'h1388);
    rchk("coil_res", 12'h010, 32'h05DC);
    rchk("coil_tmp", 12'h014, 32'h0093);
    rchk("in_power", 12'h024, 32'h0032);
    rchk("an_one", 12'h038, 32'h03E8);
    rchk("an_two", 12'h03C, 32'h01F4);
    rchk("cur_ref", 12'h040, 32'h00FA);
    rchk("cur_fb", 12'h044, 32'h03E8);
    rchk("hs_tmp", 12'h05C, 32'h0123);
    rchk("amb_tmp", 12'h060, 32'h00FA);
    rchk("duty_one", 12'h068, 32'h03E8);
    rchk("duty_two", 12'h06C, 32'h0000);
    rchk("hours", 12'h034, 32'h0000);
    rchk("cmd_ref", 12'h020, 32'h0155);
    // Leave steady state and move the voltage: resistance must hold
    stdy <= 1'b0;
    t1v  <= 16'h0BB8;
    tick(5);
    rchk("coil_res_hold", 12'h010, 32'h05DC);
    rchk("mag_volt", 12'h008, 32'h09C4);
    stdy <= 1'b1;
    t1v  <= 16'h07D0;
    $display("Test measurements done");
    {run, drop, flt, ext, batt} <= 5'h1F;
    tick(5);
    rchk("in_pins", 12'h054, 32'h1F7F);
    rchk("out_pins", 12'h058, 32'h0015);
    for (int c = 1; c < 4; c++)
    begin
      fcode <= c[4:0];
      tick(5);
      rchk("ctl_flags", 12'h074, (c < 3) ? 32'h48C3 : 32'h4843);
    end
    {run, drop, flt, ext, batt} <= 5'h00;
    lin <= 13'h0081;
    drv <= 5'h02;
    tick(5);
    rchk("in_pins", 12'h054, 32'h0001);
    rchk("out_pins", 12'h058, 32'h0002);
    rchk("ctl_flags", 12'h074, 32'h0000);
    $display("Test status words done");
    bus(1'b1, 12'h000, 32'h0000_1234);
    `CHK("wr_err", 1'b1, err)
    rchk("mag_cur", 12'h000, 32'h03E8);
    bus(1'b0, 12'h004, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    $display("Test refusals done");
    for (int k = 0; k < 99; k++)
      pulse();
    rchk("ops_units", 12'h02C, 32'h0063);
    rchk("ops_hund", 12'h030, 32'h0000);
    pulse();
    rchk("ops_units", 12'h02C, 32'h0000);
    rchk("ops_hund", 12'h030, 32'h0001);
    bus(1'b1, 12'h02C, 32'h0000_0005);
    rchk("ops_units", 12'h02C, 32'h0000);
    $display("Test operation counters done");
    for (int k = 0; k < 5; k++)
    begin
      ambt <= amb_tab[k];
      tick(4);
      fchk("amb_fault", af_tab[k], 1'b0);
    end
    $display("Test ambient fault done");
    t1c <= 16'h04B0;
    a0 = cyc;
    tick(100);
    bus(1'b0, 12'h064, 32'h0);
    `CHK("ovl_rise", 1'b1, (rd >= 32'd90 && rd <= 32'd110))
    while (cyc - a0 < 17900)
      @(posedge clk);
    fchk("ovl_fault", 1'b0, 1'b1);
    while (cyc - a0 < 18100)
      @(posedge clk);
    fchk("ovl_fault", 1'b1, 1'b1);
    t1c <= 16'h01F4;
    tick(20);
    bus(1'b0, 12'h064, 32'h0);
    a0 = rd;
    tick(20);
    bus(1'b0, 12'h064, 32'h0);
    `CHK("ovl_fall", 1'b1, (rd < a0))
    tick(300);
    fchk("ovl_fault", 1'b0, 1'b1);
    $display("Test overload done");
    while (cyc < 36060)
      @(posedge clk);
    rchk("hours", 12'h034, 32'h0001);
    a0 = (cyc / 10) * 50000 / 360000;
    bus(1'b0, 12'h028, 32'h0);
    `CHK("energy", 1'b1, (rd + 2 >= a0 && rd <= a0 + 2))
    $display("Test hours and energy done");
    summarize();
  end
endmodule : lift_magnet_monitor_bank_test
`default_nettype wire
